//--- hdl/psirp_device.sv
// sensor end: two-wire slave, register map and conversion timer
`timescale 1ns/1ns
module psirp_device #(
  parameter int unsigned  CONV_T_CYC  = psirp_pkg::CONV_TEMP_CYC,
  parameter int unsigned  CONV_P0_CYC = psirp_pkg::CONV_P0_CYC,
  parameter int unsigned  CONV_P1_CYC = psirp_pkg::CONV_P1_CYC,
  parameter int unsigned  CONV_P2_CYC = psirp_pkg::CONV_P2_CYC,
  parameter int unsigned  CONV_P3_CYC = psirp_pkg::CONV_P3_CYC,
  // value is arbitrary
  parameter logic [7:0]   ID_CODE     = 8'hA5,
  parameter logic [175:0] CALIB       = {11{16'h1357}}
) (
  // clock, reset, enable
  input  wire logic        core_clk_i,
  input  wire logic        reset_n_i,
  input  wire logic        ce_i,
  // link
  psirp_if.dev             bus,
  // sensing side
  input  wire logic [15:0] raw_temperature_i,
  input  wire logic [20:0] raw_pressure_i,
  output logic             conv_busy_o
);
  import psirp_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE, ST_RX, ST_ACK_SET, ST_ACK, ST_TX, ST_MACK
  } psirp_dst_t;

  psirp_dst_t  state_r;
  logic [2:0]  scl_s_r;
  logic [2:0]  sda_s_r;
  logic        scl_f_r;
  logic        sda_f_r;
  logic        scl_q_r;
  logic        sda_q_r;
  logic [2:0]  bit_cnt_r;
  logic [7:0]  shift_r;
  logic [1:0]  phase_r;
  logic        rw_r;
  logic        mack_r;
  logic [7:0]  ptr_r;
  logic        sda_oe_r;
  logic        sda_o_r;
  logic [7:0]  ctrl_r;
  logic        busy_r;
  logic [21:0] conv_cnt_r;
  logic [7:0]  res_hi_r;
  logic [7:0]  res_lo_r;
  logic [7:0]  res_xl_r;
  logic        scl_rise;
  logic        scl_fall;
  logic        start_c;
  logic        stop_c;
  logic [7:0]  rx_byte;
  logic        byte_done;
  logic        wr_en;
  logic [7:0]  rd_byte;

  // filtered pins: a level counts once stages two and three agree
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      scl_s_r <= 3'h7;
      sda_s_r <= 3'h7;
      scl_f_r <= 1'b1;
      sda_f_r <= 1'b1;
      scl_q_r <= 1'b1;
      sda_q_r <= 1'b1;
    end else if (ce_i) begin
      scl_s_r <= {scl_s_r[1:0], bus.scl};
      sda_s_r <= {sda_s_r[1:0], bus.sda};
      if (scl_s_r[1] == scl_s_r[2]) scl_f_r <= scl_s_r[2];
      if (sda_s_r[1] == sda_s_r[2]) sda_f_r <= sda_s_r[2];
      scl_q_r <= scl_f_r;
      sda_q_r <= sda_f_r;
    end
  end

  // edge detect
  // no spike filter beyond the agree stage, so high-speed edges pass
  assign scl_rise  = scl_f_r & ~scl_q_r;
  assign scl_fall  = ~scl_f_r & scl_q_r;
  assign start_c   = scl_f_r & scl_q_r & sda_q_r & ~sda_f_r;
  assign stop_c    = scl_f_r & scl_q_r & ~sda_q_r & sda_f_r;
  assign rx_byte   = {shift_r[6:0], sda_f_r};
  assign byte_done = (state_r == ST_RX) && scl_rise && (bit_cnt_r == 3'h7);
  assign wr_en     = byte_done && (phase_r == 2'h2) && !rw_r;

  // read mux
  always_comb begin
    rd_byte = 8'h00;
    if (ptr_r >= REG_CALIB_FIRST && ptr_r <= REG_CALIB_LAST) begin
      rd_byte = CALIB[175 - 8 * (ptr_r - REG_CALIB_FIRST) -: 8];
    end else begin
      case (ptr_r)
        REG_ID:     rd_byte = ID_CODE;
        REG_CTRL:   rd_byte = {ctrl_r[7:6], busy_r, ctrl_r[4:0]};
        REG_RES_HI: rd_byte = res_hi_r;
        REG_RES_LO: rd_byte = res_lo_r;
        REG_RES_XL: rd_byte = res_xl_r;
        default:    rd_byte = 8'h00;
      endcase
    end
  end

  // protocol engine
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_r   <= ST_IDLE;
      bit_cnt_r <= 3'h0;
      shift_r   <= 8'h00;
      phase_r   <= 2'h0;
      rw_r      <= 1'b0;
      mack_r    <= 1'b0;
      ptr_r     <= 8'h00;
      sda_oe_r  <= 1'b0;
    end else if (ce_i) begin
      if (stop_c) begin
        state_r  <= ST_IDLE;
        sda_oe_r <= 1'b0;
      end else if (start_c) begin
        state_r   <= ST_RX;
        bit_cnt_r <= 3'h0;
        phase_r   <= 2'h0;
        sda_oe_r  <= 1'b0;
      end else begin
        case (state_r)
          ST_RX: begin
            if (scl_rise) begin
              shift_r   <= rx_byte;
              bit_cnt_r <= bit_cnt_r + 3'h1;
            end
            if (byte_done) begin
              if (phase_r == 2'h0 && rx_byte[7:1] != DEV_ADDR) begin
                state_r <= ST_IDLE;
              end else begin
                state_r <= ST_ACK_SET;
                if (phase_r == 2'h0) rw_r <= rx_byte[0];
                if (phase_r == 2'h1) ptr_r <= rx_byte;
                if (phase_r == 2'h2) ptr_r <= ptr_r + 8'h01;
                if (phase_r != 2'h2) phase_r <= phase_r + 2'h1;
              end
            end
          end
          ST_ACK_SET: begin
            if (scl_fall) begin
              sda_oe_r <= 1'b1;
              state_r  <= ST_ACK;
            end
          end
          ST_ACK: begin
            if (scl_fall) begin
              bit_cnt_r <= 3'h0;
              if (rw_r) begin
                shift_r  <= rd_byte;
                sda_oe_r <= ~rd_byte[7];
                state_r  <= ST_TX;
              end else begin
                sda_oe_r <= 1'b0;
                state_r  <= ST_RX;
              end
            end
          end
          ST_TX: begin
            if (scl_fall) begin
              bit_cnt_r <= bit_cnt_r + 3'h1;
              if (bit_cnt_r == 3'h7) begin
                sda_oe_r <= 1'b0;
                mack_r   <= 1'b0;
                state_r  <= ST_MACK;
              end else begin
                sda_oe_r <= ~shift_r[6];
                shift_r  <= {shift_r[6:0], 1'b0};
              end
            end
          end
          ST_MACK: begin
            if (scl_rise) begin
              if (!sda_f_r) begin
                mack_r <= 1'b1;
                ptr_r  <= ptr_r + 8'h01;
              end else begin
                state_r <= ST_IDLE;
              end
            end else if (scl_fall && mack_r) begin
              bit_cnt_r <= 3'h0;
              shift_r   <= rd_byte;
              sda_oe_r  <= ~rd_byte[7];
              state_r   <= ST_TX;
            end
          end
          default: state_r <= ST_IDLE;
        endcase
      end
    end
  end

  // control, conversion timer and results
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ctrl_r     <= CTRL_RST;
      busy_r     <= 1'b0;
      conv_cnt_r <= 22'h0;
      res_hi_r   <= RES_HI_RST;
      res_lo_r   <= RES_LO_RST;
      res_xl_r   <= RES_XL_RST;
    end else if (ce_i) begin
      if (wr_en && ptr_r == REG_SOFT_RST && rx_byte == SOFT_RST_KEY) begin
        ctrl_r     <= CTRL_RST;
        busy_r     <= 1'b0;
        conv_cnt_r <= 22'h0;
        res_hi_r   <= RES_HI_RST;
        res_lo_r   <= RES_LO_RST;
        res_xl_r   <= RES_XL_RST;
      end else if (wr_en && ptr_r == REG_CTRL) begin
        ctrl_r <= rx_byte;
        busy_r <= rx_byte[CTRL_SCO_BIT];
        if (rx_byte[4:0] == MC_PRES) begin
          case (rx_byte[7:6])
            2'h0:    conv_cnt_r <= 22'(CONV_P0_CYC - 1);
            2'h1:    conv_cnt_r <= 22'(CONV_P1_CYC - 1);
            2'h2:    conv_cnt_r <= 22'(CONV_P2_CYC - 1);
            default: conv_cnt_r <= 22'(CONV_P3_CYC - 1);
          endcase
        end else begin
          conv_cnt_r <= 22'(CONV_T_CYC - 1);
        end
      end else if (busy_r) begin
        if (conv_cnt_r == 22'h0) begin
          busy_r <= 1'b0;
          if (ctrl_r[4:0] == MC_PRES) begin
            res_hi_r <= raw_pressure_i[20:13];
            res_lo_r <= raw_pressure_i[12:5];
            res_xl_r <= {raw_pressure_i[4:0], 3'h0};
          end else begin
            res_hi_r <= raw_temperature_i[15:8];
            res_lo_r <= raw_temperature_i[7:0];
            res_xl_r <= 8'h00;
          end
        end else begin
          conv_cnt_r <= conv_cnt_r - 22'h1;
        end
      end
    end
  end

  // open drain: output level fixed low, enable pulls the line
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) sda_o_r <= 1'b0;
    else if (ce_i) sda_o_r <= 1'b0;
  end

  assign bus.dev_sda_o  = sda_o_r;
  assign bus.dev_sda_oe = sda_oe_r;
  assign conv_busy_o    = busy_r;
endmodule : psirp_device

//--- hdl/psirp_pkg.sv
// shared constants for the pressure sensor two-wire register port
package psirp_pkg;
  // bus address and register map
  localparam logic [6:0] DEV_ADDR        = 7'h77;
  localparam logic [7:0] REG_CALIB_FIRST = 8'hAA;
  localparam logic [7:0] REG_CALIB_LAST  = 8'hBF;
  localparam logic [7:0] REG_ID          = 8'hD0;
  localparam logic [7:0] REG_SOFT_RST    = 8'hE0;
  localparam logic [7:0] REG_CTRL        = 8'hF4;
  localparam logic [7:0] REG_RES_HI      = 8'hF6;
  localparam logic [7:0] REG_RES_LO      = 8'hF7;
  localparam logic [7:0] REG_RES_XL      = 8'hF8;
  // reset values and keys
  localparam logic [7:0] CTRL_RST        = 8'h00;
  localparam logic [7:0] RES_HI_RST      = 8'h80;
  localparam logic [7:0] RES_LO_RST      = 8'h00;
  localparam logic [7:0] RES_XL_RST      = 8'h00;
  localparam logic [7:0] SOFT_RST_KEY    = 8'hB6;
  // control register fields
  localparam int         CTRL_SCO_BIT    = 5;
  localparam logic [4:0] MC_TEMP         = 5'h0E;
  localparam logic [4:0] MC_PRES         = 5'h14;
  localparam logic [7:0] CMD_TEMP        = 8'h2E;
  localparam logic [7:0] CMD_PRES_OSS0   = 8'h34;
  localparam int         CALIB_BYTES     = 22;
  // timing, clock period in ns
  localparam real        CLK_PERIOD_NS   = 8.0;
  localparam real        CONV_TEMP_MS    = 4.5;
  localparam real        CONV_P0_MS      = 4.5;
  localparam real        CONV_P1_MS      = 7.5;
  localparam real        CONV_P2_MS      = 13.5;
  localparam real        CONV_P3_MS      = 25.5;
  localparam real        STARTUP_MS      = 10.0;
  localparam int CONV_TEMP_CYC = int'($floor(CONV_TEMP_MS * 1.0E6 / CLK_PERIOD_NS));
  localparam int CONV_P0_CYC   = int'($floor(CONV_P0_MS * 1.0E6 / CLK_PERIOD_NS));
  localparam int CONV_P1_CYC   = int'($floor(CONV_P1_MS * 1.0E6 / CLK_PERIOD_NS));
  localparam int CONV_P2_CYC   = int'($floor(CONV_P2_MS * 1.0E6 / CLK_PERIOD_NS));
  localparam int CONV_P3_CYC   = int'($floor(CONV_P3_MS * 1.0E6 / CLK_PERIOD_NS));
  localparam int STARTUP_CYC   = int'($ceil(STARTUP_MS * 1.0E6 / CLK_PERIOD_NS));
  localparam int SCL_HALF_CYC  = 10;
  // host command port registers
  localparam logic [2:0] HREG_TARGET     = 3'h0;
  localparam logic [2:0] HREG_WDATA      = 3'h1;
  localparam logic [2:0] HREG_CTRL       = 3'h2;
  localparam logic [2:0] HREG_STATUS     = 3'h3;
  localparam logic [2:0] HREG_RDATA0     = 3'h4;
  localparam logic [2:0] HREG_RDATA1     = 3'h5;
  localparam logic [2:0] HREG_RDATA2     = 3'h6;
  localparam int         HCTRL_GO_WR     = 0;
  localparam int         HCTRL_GO_RD     = 1;
  localparam int         HCTRL_LEN_LO    = 2;
endpackage : psirp_pkg

//--- hdl/psirp_if.sv
// open-drain two-wire link between host and sensor port
`timescale 1ns/1ns
interface psirp_if;
  logic host_scl_o;
  logic host_scl_oe;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic scl;
  logic sda;
  // wired-and with pull-ups
  assign scl = ~(host_scl_oe & ~host_scl_o);
  assign sda = ~(host_sda_oe & ~host_sda_o) & ~(dev_sda_oe & ~dev_sda_o);
  modport dev  (input scl, sda, output dev_sda_o, dev_sda_oe);
  modport host (input scl, sda,
                output host_scl_o, host_scl_oe, host_sda_o, host_sda_oe);
endinterface : psirp_if

//--- hdl/psirp_host.sv
// host end: two-wire master driven by a small command register port
`timescale 1ns/1ns
module psirp_host #(
  parameter int unsigned SCL_HALF = psirp_pkg::SCL_HALF_CYC,
  parameter int unsigned STARTUP  = psirp_pkg::STARTUP_CYC
) (
  // clock, reset, enable
  input  wire logic       core_clk_i,
  input  wire logic       reset_n_i,
  input  wire logic       ce_i,
  // link
  psirp_if.host           bus,
  // command port
  input  wire logic [2:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  output logic [7:0]      rdata_o
);
  import psirp_pkg::*;

  typedef enum logic [1:0] {H_IDLE, H_START, H_BIT, H_STOP} psirp_hst_t;

  psirp_hst_t  st_r;
  logic [2:0]  sda_s_r;
  logic        sda_f_r;
  logic [20:0] up_cnt_r;
  logic        ready_r;
  logic [7:0]  target_r;
  logic [7:0]  wdata_r;
  logic        op_rd_r;
  logic [1:0]  len_r;
  logic        busy_r;
  logic        nack_r;
  logic [7:0]  rbuf_r [0:2];
  logic [7:0]  rdata_r;
  logic [15:0] div_r;
  logic [1:0]  ph_r;
  logic [3:0]  bit_r;
  logic [2:0]  byte_r;
  logic [7:0]  rx_r;
  logic        scl_oe_r;
  logic        sda_oe_r;
  logic        tick;
  logic        is_tx;
  logic        last_rx;
  logic [7:0]  tx_byte;
  logic        go;

  assign tick    = (div_r == 16'h0);
  assign is_tx   = (byte_r < 3'h3);
  assign last_rx = (byte_r == 3'h2 + {1'b0, len_r});
  assign go      = wr_i && addr_i == HREG_CTRL && !busy_r && ready_r &&
                   (wdata_i[HCTRL_GO_WR] || wdata_i[HCTRL_GO_RD]);

  always_comb begin
    case (byte_r)
      3'h0:    tx_byte = {DEV_ADDR, 1'b0};
      3'h1:    tx_byte = target_r;
      default: tx_byte = op_rd_r ? {DEV_ADDR, 1'b1} : wdata_r;
    endcase
  end

  // data pin filter, same scheme as the sensor end
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sda_s_r <= 3'h7;
      sda_f_r <= 1'b1;
    end else if (ce_i) begin
      sda_s_r <= {sda_s_r[1:0], bus.sda};
      if (sda_s_r[1] == sda_s_r[2]) sda_f_r <= sda_s_r[2];
    end
  end

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      up_cnt_r <= 21'h0;
      ready_r  <= 1'b0;
    end else if (ce_i && !ready_r) begin
      up_cnt_r <= up_cnt_r + 21'h1;
      if (up_cnt_r == 21'(STARTUP - 1)) ready_r <= 1'b1;
    end
  end

  // command registers
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      target_r <= 8'h00;
      wdata_r  <= 8'h00;
      op_rd_r  <= 1'b0;
      len_r    <= 2'h2;
      rdata_r  <= 8'h00;
    end else if (ce_i) begin
      if (wr_i && addr_i == HREG_TARGET && !busy_r) target_r <= wdata_i;
      if (wr_i && addr_i == HREG_WDATA && !busy_r) wdata_r <= wdata_i;
      if (go) begin
        op_rd_r <= wdata_i[HCTRL_GO_RD];
        len_r   <= (wdata_i[HCTRL_LEN_LO+:2] == 2'h0) ? 2'h1
                   : wdata_i[HCTRL_LEN_LO+:2];
      end
      rdata_r <= 8'h00;
      if (rd_i) begin
        case (addr_i)
          HREG_TARGET: rdata_r <= target_r;
          HREG_WDATA:  rdata_r <= wdata_r;
          HREG_CTRL:   rdata_r <= {4'h0, len_r, op_rd_r, 1'b0};
          HREG_STATUS: rdata_r <= {5'h00, ready_r, nack_r, busy_r};
          HREG_RDATA0: rdata_r <= rbuf_r[0];
          HREG_RDATA1: rdata_r <= rbuf_r[1];
          HREG_RDATA2: rdata_r <= rbuf_r[2];
          default:     rdata_r <= 8'h00;
        endcase
      end
    end
  end

  // bit engine; scl made here by dividing the core clock
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_r     <= H_IDLE;
      busy_r   <= 1'b0;
      nack_r   <= 1'b0;
      div_r    <= 16'h0;
      ph_r     <= 2'h0;
      bit_r    <= 4'h0;
      byte_r   <= 3'h0;
      rx_r     <= 8'h00;
      scl_oe_r <= 1'b0;
      sda_oe_r <= 1'b0;
      rbuf_r   <= '{8'h00, 8'h00, 8'h00};
    end else if (ce_i) begin
      div_r <= tick ? 16'(SCL_HALF - 1) : div_r - 16'h1;
      if (st_r == H_IDLE) begin
        if (go) begin
          st_r   <= H_START;
          busy_r <= 1'b1;
          nack_r <= 1'b0;
          ph_r   <= 2'h0;
          byte_r <= 3'h0;
        end
      end else if (tick) begin
        case (st_r)
          H_START: begin
            ph_r <= ph_r + 2'h1;
            case (ph_r)
              2'h0: sda_oe_r <= 1'b0;
              2'h1: scl_oe_r <= 1'b0;
              2'h2: sda_oe_r <= 1'b1;
              default: begin
                scl_oe_r <= 1'b1;
                bit_r    <= 4'h0;
                st_r     <= H_BIT;
              end
            endcase
          end
          H_BIT: begin
            case (ph_r)
              2'h0: begin
                ph_r <= 2'h1;
                if (bit_r < 4'h8) sda_oe_r <= is_tx & ~tx_byte[3'(7 - bit_r)];
                else              sda_oe_r <= ~is_tx & ~last_rx;
              end
              2'h1: begin
                ph_r     <= 2'h2;
                scl_oe_r <= 1'b0;
              end
              default: begin
                ph_r     <= 2'h0;
                scl_oe_r <= 1'b1;
                bit_r    <= bit_r + 4'h1;
                if (bit_r < 4'h8) rx_r <= {rx_r[6:0], sda_f_r};
                if (bit_r == 4'h8) begin
                  if (!is_tx) rbuf_r[2'(byte_r - 3'h3)] <= rx_r;
                  bit_r <= 4'h0;
                  if (is_tx && sda_f_r) begin
                    nack_r <= 1'b1;
                    st_r   <= H_STOP;
                  end else if (!op_rd_r && byte_r == 3'h2) begin
                    st_r <= H_STOP;
                  end else if (op_rd_r && byte_r == 3'h1) begin
                    byte_r <= 3'h2;
                    st_r   <= H_START;
                  end else if (op_rd_r && last_rx) begin
                    st_r <= H_STOP;
                  end else begin
                    byte_r <= byte_r + 3'h1;
                  end
                end
              end
            endcase
          end
          H_STOP: begin
            ph_r <= ph_r + 2'h1;
            case (ph_r)
              2'h0: sda_oe_r <= 1'b1;
              2'h1: scl_oe_r <= 1'b0;
              default: begin
                sda_oe_r <= 1'b0;
                busy_r   <= 1'b0;
                st_r     <= H_IDLE;
              end
            endcase
          end
          default: st_r <= H_IDLE;
        endcase
      end
    end
  end

  assign bus.host_scl_o  = 1'b0;
  assign bus.host_sda_o  = 1'b0;
  assign bus.host_scl_oe = scl_oe_r;
  assign bus.host_sda_oe = sda_oe_r;
  assign rdata_o         = rdata_r;
endmodule : psirp_host

//--- dv/psirp_link_sva.sv
// link checker for the host and sensor ends
`timescale 1ns/1ns
module psirp_link_sva (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  // link
  input wire logic scl,
  input wire logic sda,
  input wire logic host_scl_oe,
  input wire logic host_sda_oe,
  input wire logic dev_sda_oe
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);
  sequence s_scl_low; !scl[*8]; endsequence
  sequence s_dev_bit; dev_sda_oe throughout (##[1:30] scl); endsequence
  property p_drive_low; $rose(dev_sda_oe) |-> !scl; endproperty
  a_drive_low: assert property (p_drive_low)
    else $error("device took sda while scl high");
  // bit held until the master clocks it
  property p_bit_held; $rose(dev_sda_oe) |-> s_dev_bit; endproperty
  a_bit_held: assert property (p_bit_held)
    else $error("device let go of sda before scl rose");
  property p_stable_high;
    scl && $past(scl) |-> $stable(dev_sda_oe);
  endproperty
  a_stable_high: assert property (p_stable_high)
    else $error("device changed sda while scl high");
  property p_scl_high; $rose(scl) |-> scl[*8]; endproperty
  a_scl_high: assert property (p_scl_high)
    else $error("scl high phase too short");
  property p_scl_low; $fell(scl) |-> s_scl_low; endproperty
  a_scl_low: assert property (p_scl_low)
    else $error("scl low phase too short");
  property p_idle_reset;
    $rose(reset_n_i) |-> scl && sda && !dev_sda_oe;
  endproperty
  a_idle_reset: assert property (p_idle_reset)
    else $error("link not idle after reset");
  // only the master may make start conditions
  property p_start_host; $fell(sda) && scl |-> host_sda_oe; endproperty
  a_start_host: assert property (p_start_host)
    else $error("sda fell with scl high not from host");
  property p_no_clash;
    $rose(scl) |-> !(dev_sda_oe && host_sda_oe);
  endproperty
  a_no_clash: assert property (p_no_clash)
    else $error("both ends drive sda at scl rise");
endmodule : psirp_link_sva

//--- dv/tb_top.sv
// self-checking bench for both link ends
`timescale 1ns/1ns
module tb_top;
  import psirp_pkg::*;
  // value is arbitrary
  localparam logic [7:0] ID_T = 8'hA5;
  logic core_clk_i = 1'b0;
  logic ce = 1'b1;
  logic reset_n_i = 1'b0;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] rdata;
  logic busy;
  logic [15:0] temp = 16'hC3A5;
  logic [20:0] pres = 21'h1B2C7;
  logic [7:0] b [3];
  logic [7:0] cmd [5] = '{8'h2E, 8'h34, 8'h74, 8'hB4, 8'hF4};
  int cyc [5] = '{2000, 2100, 2400, 2700, 3000};
  int fails = 0, n_compared = 0, cyc_n = 0, bcnt = 0, blen = 0;
  psirp_if bus_if ();
  psirp_device #(.CONV_T_CYC(2000), .CONV_P0_CYC(2100),
    .CONV_P1_CYC(2400), .CONV_P2_CYC(2700), .CONV_P3_CYC(3000))
    i_psirp_device (
    .core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .ce_i(ce),
    .bus(bus_if.dev), .raw_temperature_i(temp),
    .raw_pressure_i(pres), .conv_busy_o(busy));
  psirp_host #(.STARTUP(20)) i_psirp_host (
    .core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .ce_i(ce),
    .bus(bus_if.host), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
    .rd_i(rd), .rdata_o(rdata));
  psirp_link_sva i_psirp_link_sva (
    .core_clk_i(core_clk_i), .reset_n_i(reset_n_i),
    .scl(bus_if.scl), .sda(bus_if.sda),
    .host_scl_oe(bus_if.host_scl_oe), .host_sda_oe(bus_if.host_sda_oe),
    .dev_sda_oe(bus_if.dev_sda_oe));
  always #4 core_clk_i = ~core_clk_i;
  // busy length kept when busy drops; ceiling cuts a hang
  always @(posedge core_clk_i) begin
    cyc_n <= cyc_n + 1;
    if (busy === 1'b1) begin
      bcnt <= bcnt + 1;
    end else begin
      if (bcnt != 0) blen <= bcnt;
      bcnt <= 0;
    end
    if (cyc_n == 90000) begin
      fails++;
      end_sim();
    end
  end
  task automatic end_sim();
    if (fails == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : end_sim
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    n_compared++;
    if (s !== e) begin
      fails++;
      $display("MISMATCH t=%0t seen %h want %h", $time, s, e);
    end
  endtask : chk
  task automatic pw(input logic [2:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge core_clk_i);
    wr <= 1'b0;
  endtask : pw
  task automatic pr(input logic [2:0] a, output logic [7:0] d);
    @(posedge core_clk_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge core_clk_i);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : pr
  // poll until the transfer ends; busy and nack must both be clear
  task automatic idle();
    logic [7:0] s;
    int n;
    n = 0;
    do begin
      pr(HREG_STATUS, s);
      n++;
    end while (s[0] !== 1'b0 && n < 3000);
    chk(s & 8'h03, 8'h00);
  endtask : idle
  task automatic bw(input logic [7:0] r, input logic [7:0] d);
    pw(HREG_TARGET, r);
    pw(HREG_WDATA, d);
    pw(HREG_CTRL, 8'h01);
    idle();
  endtask : bw
  task automatic br(input logic [7:0] r, input logic [1:0] n);
    pw(HREG_TARGET, r);
    pw(HREG_CTRL, {4'h0, n, 2'b10});
    idle();
    for (int i = 0; i < 3; i++) pr(HREG_RDATA0 + 3'(i), b[i]);
  endtask : br
  initial begin
    logic [7:0] st;
    int n;
    repeat (3) @(posedge core_clk_i);
    reset_n_i <= 1'b1;
    repeat (25) @(posedge core_clk_i);
    pr(HREG_STATUS, st);
    chk(st & 8'h04, 8'h04);
    br(REG_ID, 2'd1);
    chk(b[0], ID_T);
    bw(REG_ID, 8'h00);
    br(REG_ID, 2'd1);
    chk(b[0], ID_T);
    br(REG_CALIB_FIRST, 2'd2);
    chk(b[0], 8'h13);
    chk(b[1], 8'h57);
    br(REG_CALIB_LAST, 2'd1);
    chk(b[0], 8'h57);
    br(8'h00, 2'd1);
    chk(b[0], 8'h00);
    br(REG_SOFT_RST, 2'd1);
    chk(b[0], 8'h00);
    for (int k = 0; k < 5; k++) begin
      bw(REG_CTRL, cmd[k]);
      br(REG_CTRL, 2'd1);
      chk(b[0], cmd[k]);
      n = 0;
      while (busy !== 1'b0 && n < 4000) begin
        @(posedge core_clk_i);
        n++;
      end
      repeat (2) @(posedge core_clk_i);
      chk(8'(blen <= cyc[k] + 1 && blen + 1 >= cyc[k]), 8'h01);
      br(REG_CTRL, 2'd1);
      chk(b[0], cmd[k] & 8'hDF);
      br(REG_RES_HI, 2'd3);
      chk(b[0], k ? pres[20:13] : temp[15:8]);
      chk(b[1], k ? pres[12:5] : temp[7:0]);
      if (k > 0) chk(b[2], {pres[4:0], 3'b000});
      br(REG_RES_LO, 2'd1);
      chk(b[0], k ? pres[12:5] : temp[7:0]);
      temp <= temp + 16'h1111;
      pres <= pres ^ 21'h0F0F0;
    end
    bw(REG_CTRL, CMD_TEMP);
    chk({7'h0, busy}, 8'h01);
    // enable low must freeze the conversion timer past its end
    ce <= 1'b0;
    repeat (2500) @(posedge core_clk_i);
    chk({7'h0, busy}, 8'h01);
    ce <= 1'b1;
    bw(REG_SOFT_RST, SOFT_RST_KEY);
    chk({7'h0, busy}, 8'h00);
    br(REG_CTRL, 2'd1);
    chk(b[0], CTRL_RST);
    br(REG_RES_HI, 2'd3);
    chk(b[0], RES_HI_RST);
    chk(b[1], RES_LO_RST);
    chk(b[2], RES_XL_RST);
    end_sim();
  end
endmodule : tb_top
